// ==== his_pkg.sv ====
/*
 * Shared constants and carriers for the identification and status register pair
 * of the frame-rate converter host register file.
 * Assumes a host interface on the same clock presents decoded register reads.
 */
//
// Behaviour
// - ID register 00: read-only revision plus product
// - Status register 01 is read-only state
// - Bit 0 low during SDRAM init
// - Bit 1 shows odd pin or decoded
// - Bit 2 sets on input buffer overrun
// - Bits 2-9 stay set until read
// - Bit 3 sets when odd fails toggling
// - Bit 4 sets on vsync time-out
// - Bit 5 sets on mid-active hsync
// - Bit 6 sets on mid-active vsync
// - Bit 7 sets on YUV vsync edge
// - Bit 8 sets on RGB vsync edge
// - Bit 9 sets on output vsync
// - Bit 10 sets on measurement done
// - Measurement flag clears on select change
package his_pkg;

	// Register bus geometry
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned REG_W  = 12;

	// Register addresses
	localparam logic [ADDR_W-1:0] ADDR_CHIP_ID = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h01;

	// Identification field layout
	localparam int unsigned REV_LSB  = 0;
	localparam int unsigned REV_W    = 4;
	localparam int unsigned PROD_LSB = 4;
	localparam int unsigned PROD_W   = 8;

	// Status bit positions
	localparam int unsigned ST_MEM_READY   = 0;
	localparam int unsigned ST_PARITY      = 1;
	localparam int unsigned ST_OVERRUN     = 2;
	localparam int unsigned ST_PARITY_ERR  = 3;
	localparam int unsigned ST_VS_TIMEOUT  = 4;
	localparam int unsigned ST_MID_HSYNC   = 5;
	localparam int unsigned ST_MID_VSYNC   = 6;
	localparam int unsigned ST_YUV_VS      = 7;
	localparam int unsigned ST_RGB_VS      = 8;
	localparam int unsigned ST_OUT_VS      = 9;
	localparam int unsigned ST_MEASUREMENT_COMPLETE_FLAG  = 10;
	localparam int unsigned STICKY_LO      = 2;
	localparam int unsigned STICKY_HI      = 9;

	// Vertical sync time-out, in frame store clock periods (2^22)
	localparam int unsigned VS_TIMEOUT_PERIODS = 32'h0040_0000;
	localparam int unsigned VS_CNT_W           = 23;

	// Reset values
	localparam logic [REG_W-1:0] STATUS_RST = 12'h000;
	localparam logic [REG_W-1:0] RDATA_RST  = 12'h000;

	// Single-cycle events raised by capture, frame store and measurement logic
	typedef struct packed {
		logic overrun;     // Input buffer overflow
		logic mid_hsync;   // Hsync edge inside horizontal active
		logic mid_vsync;   // Vsync edge inside vertical active
		logic meas_done;   // Sync measurement finished
	} his_evt_s;

	// Measurement selection settings
	typedef struct packed {
		logic sync_type;   // Vertical versus horizontal sync
		logic period_sel;  // Period versus active length
	} his_meas_sel_s;

endpackage : his_pkg

// ==== his_status_regs.sv ====
/*
 * Identification and status register pair: fixed identity word, live state
 * bits, sticky event flags cleared by a status read, sync detectors.
 * Assumes the host interface decodes reads into a one-cycle strobe with an
 * address on ref_clk; parity and input vsync pins arrive asynchronously and are synchronised here.
 */
`timescale 1ns/10ps

module his_status_regs #(
	parameter logic [3:0]  REVISION_CODE   = 4'h5,   // Arbitrary value
	parameter logic [7:0]  PRODUCT_CODE    = 8'hA7,  // Arbitrary value
	parameter int unsigned VS_TIMEOUT_CYC  = his_pkg::VS_TIMEOUT_PERIODS
) (
	input  wire logic                       ref_clk,
	input  wire logic                       nrst,
	input  wire logic                       rd_strobe,
	input  wire logic [his_pkg::ADDR_W-1:0] rd_addr,
	output logic      [his_pkg::REG_W-1:0]  rd_data_q,
	output logic                            rd_valid_q,
	input  wire logic                       soft_reset,
	input  wire logic                       mem_init_done,
	input  wire logic                       input_field_parity_pin,
	input  wire logic                       decoded_field_parity,
	input  wire logic                       rgb_interlaced_input,
	input  wire logic                       external_rgb_parity_enable,
	input  wire logic                       interlaced_mode,
	input  wire logic                       rgb_input_select,
	input  wire logic                       yuv_input_vertical_sync,
	input  wire logic                       rgb_input_vertical_sync,
	input  wire logic                       output_vertical_sync_pin,
	input  wire his_pkg::his_evt_s          events,
	input  wire his_pkg::his_meas_sel_s     meas_sel,
	output logic                            frame_memory_available_q
);

	// Synchroniser chains for asynchronous pins: parity, yuv vs, rgb vs
	localparam int unsigned NSYNC = 3;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;
	logic [NSYNC-1:0] sync3_q;

	assign pin_raw = {rgb_input_vertical_sync, yuv_input_vertical_sync, input_field_parity_pin};

	// Two flops per pin, then a third stage for edge detection
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
					sync3_q[gi] <= 1'b0;
				end else begin
					sync1_q[gi] <= pin_raw[gi];
					sync2_q[gi] <= sync1_q[gi];
					sync3_q[gi] <= sync2_q[gi];
				end
			end
		end
	endgenerate

	// Synchronised levels and active (rising) edges
	logic parity_pin_s;
	logic yuv_vs_edge;
	logic rgb_vs_edge;
	logic sel_vs_edge;

	assign parity_pin_s = sync2_q[0];
	assign yuv_vs_edge  = sync2_q[1] & ~sync3_q[1];
	assign rgb_vs_edge  = sync2_q[2] & ~sync3_q[2];
	assign sel_vs_edge  = rgb_input_select ? rgb_vs_edge : yuv_vs_edge;

	// Live parity: decoded state for RGB interlaced without external parity
	logic parity_live;
	assign parity_live = (rgb_interlaced_input && !external_rgb_parity_enable)
		? decoded_field_parity : parity_pin_s;

	// Memory ready, field parity history, output vsync edge, time-out counter
	logic                        mem_rdy_q;
	logic                        mem_rdy_d;
	logic                        last_parity_q;
	logic                        last_parity_d;
	logic                        parity_seen_q;
	logic                        parity_seen_d;
	logic                        out_vs_q;
	logic                        out_vs_d;
	logic [his_pkg::VS_CNT_W-1:0] vs_cnt_q;
	logic [his_pkg::VS_CNT_W-1:0] vs_cnt_d;
	logic                        parity_err_evt;
	logic                        vs_timeout_evt;
	logic                        out_vs_evt;

	localparam logic [his_pkg::VS_CNT_W-1:0] VS_LAST =
		his_pkg::VS_CNT_W'(VS_TIMEOUT_CYC - 1);

	// Detector next-state logic
	always_comb begin
		mem_rdy_d      = mem_rdy_q;
		last_parity_d  = last_parity_q;
		parity_seen_d  = parity_seen_q;
		out_vs_d       = output_vertical_sync_pin;
		vs_cnt_d       = vs_cnt_q + his_pkg::VS_CNT_W'(1);
		parity_err_evt = 1'b0;
		vs_timeout_evt = 1'b0;
		out_vs_evt     = output_vertical_sync_pin & ~out_vs_q;
		// Low during init after any reset, high once memory is usable
		if (soft_reset) begin
			mem_rdy_d = 1'b0;
		end else if (mem_init_done) begin
			mem_rdy_d = 1'b1;
		end
		// Parity must differ at each vsync in interlaced modes
		if (sel_vs_edge) begin
			last_parity_d = parity_live;
			parity_seen_d = interlaced_mode;
			if (interlaced_mode && parity_seen_q && (parity_live == last_parity_q)) begin
				parity_err_evt = 1'b1;
			end
		end
		// Time-out when no vsync for the programmed number of periods
		if (sel_vs_edge) begin
			vs_cnt_d = '0;
		end else if (vs_cnt_q == VS_LAST) begin
			vs_cnt_d       = '0;
			vs_timeout_evt = 1'b1;
		end
	end

	// Detector registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			mem_rdy_q     <= 1'b0;
			last_parity_q <= 1'b0;
			parity_seen_q <= 1'b0;
			out_vs_q      <= 1'b0;
			vs_cnt_q      <= '0;
		end else begin
			mem_rdy_q     <= mem_rdy_d;
			last_parity_q <= last_parity_d;
			parity_seen_q <= parity_seen_d;
			out_vs_q      <= out_vs_d;
			vs_cnt_q      <= vs_cnt_d;
		end
	end

	// Sticky flags, measurement flag and read path
	logic [his_pkg::REG_W-1:0] sticky_q;
	logic [his_pkg::REG_W-1:0] sticky_d;
	logic [his_pkg::REG_W-1:0] set_vec;
	logic [his_pkg::REG_W-1:0] clr_vec;
	logic [his_pkg::REG_W-1:0] status_word;
	logic [his_pkg::REG_W-1:0] id_word;
	logic [his_pkg::REG_W-1:0] rd_data_d;
	logic                      rd_valid_d;
	logic                      measurement_complete_flag_q;
	logic                      measurement_complete_flag_d;
	his_pkg::his_meas_sel_s    meas_sel_q;
	logic                      mem_avail_d;

	// Fixed identity word
	always_comb begin
		id_word = '0;
		id_word[his_pkg::REV_LSB +: his_pkg::REV_W]   = REVISION_CODE;
		id_word[his_pkg::PROD_LSB +: his_pkg::PROD_W] = PRODUCT_CODE;
	end

	// Event sources for each sticky flag
	always_comb begin
		set_vec = '0;
		set_vec[his_pkg::ST_OVERRUN]    = events.overrun;
		set_vec[his_pkg::ST_PARITY_ERR] = parity_err_evt;
		set_vec[his_pkg::ST_VS_TIMEOUT] = vs_timeout_evt;
		set_vec[his_pkg::ST_MID_HSYNC]  = events.mid_hsync;
		set_vec[his_pkg::ST_MID_VSYNC]  = events.mid_vsync;
		set_vec[his_pkg::ST_YUV_VS]     = yuv_vs_edge;
		set_vec[his_pkg::ST_RGB_VS]     = rgb_vs_edge;
		set_vec[his_pkg::ST_OUT_VS]     = out_vs_evt;
	end

	// Assembled status word as presented to the host
	always_comb begin
		status_word = sticky_q;
		status_word[his_pkg::ST_MEM_READY]  = mem_rdy_q;
		status_word[his_pkg::ST_PARITY]     = parity_live;
		status_word[his_pkg::ST_MEASUREMENT_COMPLETE_FLAG] = measurement_complete_flag_q;
		status_word[his_pkg::REG_W-1]       = 1'b0;
	end

	// Read decode, clear-on-read and measurement flag next state
	always_comb begin
		rd_data_d    = his_pkg::RDATA_RST;
		rd_valid_d   = rd_strobe;
		clr_vec      = '0;
		measurement_complete_flag_d = measurement_complete_flag_q;
		mem_avail_d  = mem_rdy_d;
		if (rd_strobe) begin
			case (rd_addr)
				his_pkg::ADDR_CHIP_ID: begin
					rd_data_d = id_word;
				end
				his_pkg::ADDR_STATUS: begin
					rd_data_d = status_word;
					clr_vec   = sticky_q;
				end
				default: begin
					rd_data_d = his_pkg::RDATA_RST;
				end
			endcase
		end
		// Only flags returned are cleared; a new event wins over the clear
		sticky_d = (sticky_q & ~clr_vec) | set_vec;
		sticky_d[his_pkg::STICKY_LO-1:0]        = '0;
		sticky_d[his_pkg::REG_W-1:his_pkg::STICKY_HI+1] = '0;
		// Measurement flag: cleared by a selection change, set by completion
		if (meas_sel != meas_sel_q) begin
			measurement_complete_flag_d = 1'b0;
		end
		if (events.meas_done) begin
			measurement_complete_flag_d = 1'b1;
		end
	end

	// Status, read and measurement registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sticky_q                 <= his_pkg::STATUS_RST;
			rd_data_q                <= his_pkg::RDATA_RST;
			rd_valid_q               <= 1'b0;
			measurement_complete_flag_q             <= 1'b0;
			meas_sel_q               <= '0;
			frame_memory_available_q <= 1'b0;
		end else begin
			sticky_q                 <= sticky_d;
			rd_data_q                <= rd_data_d;
			rd_valid_q               <= rd_valid_d;
			measurement_complete_flag_q             <= measurement_complete_flag_d;
			meas_sel_q               <= meas_sel;
			frame_memory_available_q <= mem_avail_d;
		end
	end

endmodule : his_status_regs

// ==== his_host_model.sv ====
/* Host controller model that issues register reads to the status pair.
   Assumes the bench calls its tasks right after a rising ref_clk edge. */
`timescale 1ns/10ps
module his_host_model (
	input  wire logic                       ref_clk,
	output logic                            rd_strobe,
	output logic      [his_pkg::ADDR_W-1:0] rd_addr
);
	// Quiet bus at start
	initial begin
		rd_strobe = 1'b0;
		rd_addr   = 8'h00;
	end
	// One read cycle; register reads only, no frame store traffic
	task automatic rd(input logic [his_pkg::ADDR_W-1:0] a);
		rd_strobe <= 1'b1;
		rd_addr   <= a;
		@(posedge ref_clk);
	endtask : rd
	// Idle cycle; stale address is inverted, never held
	task automatic idle();
		rd_strobe <= 1'b0;
		rd_addr   <= ~rd_addr;
		@(posedge ref_clk);
	endtask : idle
endmodule : his_host_model

// ==== his_status_regs_assertions.sv ====
/* Checker for the identification and status pair.
   Assumes it is bound to his_status_regs and sees only its ports. */
`timescale 1ns/10ps
module his_status_regs_assertions #(
	parameter logic [3:0] REVISION_CODE = 4'h5,
	parameter logic [7:0] PRODUCT_CODE  = 8'hA7
) (
	input wire logic                       ref_clk,
	input wire logic                       nrst,
	input wire logic                       rd_strobe,
	input wire logic [his_pkg::ADDR_W-1:0] rd_addr,
	input wire logic [his_pkg::REG_W-1:0]  rd_data_q,
	input wire logic                       rd_valid_q,
	input wire logic                       soft_reset,
	input wire logic                       mem_init_done,
	input wire his_pkg::his_evt_s          events,
	input wire his_pkg::his_meas_sel_s     meas_sel,
	input wire logic                       frame_memory_available_q
);
	logic st_rd;
	// Status read request
	assign st_rd = rd_strobe && rd_addr == his_pkg::ADDR_STATUS;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	AST_RD_ANSWER:
	assert property (rd_strobe |=> rd_valid_q) else $error("read not answered");
	AST_IDLE_ZERO:
	assert property (!rd_strobe |=> !rd_valid_q && rd_data_q == 12'h000) else $error("idle data");
	AST_ID_WORD:
	assert property (rd_strobe && rd_addr == his_pkg::ADDR_CHIP_ID
		|=> rd_data_q == {PRODUCT_CODE, REVISION_CODE}) else $error("id word");
	AST_RDY_SET:
	assert property (mem_init_done && !soft_reset |=> frame_memory_available_q) else $error("ready");
	AST_RDY_CLR:
	assert property (soft_reset |=> !frame_memory_available_q) else $error("soft reset");
	AST_RDY_BIT:
	assert property (st_rd |=> rd_data_q[0] == $past(frame_memory_available_q)) else $error("bit 0");
	AST_OVR_HOLD:
	assert property (events.overrun ##1 (!rd_strobe)[*3] ##1 st_rd |=> rd_data_q[2])
		else $error("overrun lost");
	AST_MIDH:
	assert property (events.mid_hsync ##1 st_rd |=> rd_data_q[5]) else $error("mid hsync");
	AST_MIDV:
	assert property (events.mid_vsync ##1 st_rd |=> rd_data_q[6]) else $error("mid vsync");
	AST_RD_CLEAR:
	assert property (st_rd && !events.overrun ##1 st_rd && !events.overrun |=> !rd_data_q[2])
		else $error("overrun not cleared");
	AST_MEAS:
	assert property (events.meas_done ##1 (st_rd && $stable(meas_sel)) |=> rd_data_q[10])
		else $error("measurement flag");
endmodule : his_status_regs_assertions

bind his_status_regs his_status_regs_assertions #(.REVISION_CODE(REVISION_CODE),
	.PRODUCT_CODE(PRODUCT_CODE)) i_his_status_regs_assertions (.ref_clk(ref_clk),
	.nrst(nrst), .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data_q(rd_data_q),
	.rd_valid_q(rd_valid_q), .soft_reset(soft_reset), .mem_init_done(mem_init_done),
	.events(events), .meas_sel(meas_sel),
	.frame_memory_available_q(frame_memory_available_q));

// ==== his_status_regs_tb.sv ====
/* Self-checking bench for the status pair.
   Assumes the host model performs reads; sources are driven here. */
`timescale 1ns/10ps
module his_status_regs_tb;
	localparam logic [3:0] REV  = 4'h5;  // Arbitrary value
	localparam logic [7:0] PROD = 8'hA7; // Arbitrary value
	logic                  ref_clk, nrst, rd_strobe, rd_valid_q, soft_reset, mem_init_done, r, mem_avail;
	logic                  par_pin, dec_par, rgb_il, ext_en, il_mode, rgb_sel, yuv_vs, rgb_vs, out_vs;
	logic [7:0]            rd_addr;
	logic [11:0]           rd_data_q;
	his_pkg::his_evt_s     events;
	his_pkg::his_meas_sel_s meas_sel;
	int                    n_fail = 0, total_checks = 0, cyc = 0, seed = 32'h5aef7375;
	logic [23:0]           exp_q[$];
	logic [23:0]           note;

	his_host_model i_his_host_model (.ref_clk(ref_clk), .rd_strobe(rd_strobe), .rd_addr(rd_addr));
	his_status_regs #(.REVISION_CODE(REV), .PRODUCT_CODE(PROD), .VS_TIMEOUT_CYC(16))
	i_his_status_regs (.ref_clk(ref_clk), .nrst(nrst), .rd_strobe(rd_strobe),
		.rd_addr(rd_addr), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
		.soft_reset(soft_reset), .mem_init_done(mem_init_done),
		.input_field_parity_pin(par_pin), .decoded_field_parity(dec_par),
		.rgb_interlaced_input(rgb_il), .external_rgb_parity_enable(ext_en),
		.interlaced_mode(il_mode), .rgb_input_select(rgb_sel),
		.yuv_input_vertical_sync(yuv_vs), .rgb_input_vertical_sync(rgb_vs),
		.output_vertical_sync_pin(out_vs), .events(events), .meas_sel(meas_sel),
		.frame_memory_available_q(mem_avail));

	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Hang guard
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_fail++;
			print_verdict();
		end
	end
	// Compare each answer with the oldest note
	always @(negedge ref_clk) begin
		if (rd_valid_q === 1'b1) begin
			note = (exp_q.size() > 0) ? exp_q.pop_front() : 24'hFFFFFF;
			check_rd(note[23:12], note[11:0]);
			if (note[23:12] == 12'h001) begin
				check_mem(note[0]);
			end
		end
	end

	task automatic check_rd(input logic [11:0] m, input logic [11:0] e);
		total_checks++;
		if ((rd_data_q & m) !== e) begin
			n_fail++;
			$display("mismatch rd_data_q exp %h got %h", e, rd_data_q & m);
		end
	endtask : check_rd
	// Ready output against the ready bit of the same answer
	task automatic check_mem(input logic e);
		total_checks++;
		if (mem_avail !== e) begin
			n_fail++;
			$display("mismatch frame_memory_available_q exp %h got %h", e, mem_avail);
		end
	endtask : check_mem
	task automatic rd(input logic [7:0] a, input logic [11:0] m, input logic [11:0] e);
		exp_q.push_back({m, e});
		i_his_host_model.rd(a);
	endtask : rd
	task automatic step(input int n);
		repeat (n) i_his_host_model.idle();
	endtask : step
	// One-cycle pulse on soft reset, init done and the events
	task automatic pulse(input logic [5:0] e);
		{soft_reset, mem_init_done, events} <= e;
		step(1);
		{soft_reset, mem_init_done, events} <= 6'h00;
	endtask : pulse
	task automatic print_verdict();
		// Notes never answered count as one mismatch in total
		if (exp_q.size() != 0) begin
			n_fail++;
		end
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict

	// Main sequence
	initial begin
		nrst = 1'b0;
		{soft_reset, mem_init_done, events, meas_sel} = 8'h00;
		{par_pin, dec_par, rgb_il, ext_en, il_mode, rgb_sel, yuv_vs, rgb_vs, out_vs} = 9'h000;
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
		step(1);
		rd(8'h00, 12'hFFF, {PROD, REV});
		rd(8'h02 | 8'($random(seed)), 12'hFFF, 12'h000);
		rd(8'h01, 12'h001, 12'h000);
		pulse(6'h10);
		rd(8'h01, 12'h001, 12'h001);
		pulse(6'h20);
		rd(8'h01, 12'h001, 12'h000);
		pulse(6'h18);
		step(2);
		pulse(6'h06);
		rd(8'h01, 12'hFEF, 12'h065);
		rd(8'h01, 12'hFEF, 12'h001);
		{yuv_vs, rgb_vs, out_vs} <= 3'b111;
		step(6);
		rd(8'h01, 12'h380, 12'h380);
		{yuv_vs, rgb_vs, out_vs} <= 3'b000;
		step(20);
		rd(8'h01, 12'h010, 12'h010);
		il_mode <= 1'b1;
		repeat (2) begin
			yuv_vs <= 1'b1;
			step(4);
			yuv_vs <= 1'b0;
			step(4);
		end
		rd(8'h01, 12'h008, 12'h008);
		par_pin <= 1'b1;
		step(4);
		rd(8'h01, 12'h002, 12'h002);
		r = 1'($random(seed));
		rgb_il <= 1'b1;
		dec_par <= r;
		step(2);
		rd(8'h01, 12'h002, {10'h000, r, 1'b0});
		pulse(6'h01);
		rd(8'h01, 12'h400, 12'h400);
		rd(8'h01, 12'h400, 12'h400);
		meas_sel <= 2'b01;
		step(3);
		rd(8'h01, 12'h400, 12'h000);
		// External parity enabled: bit 1 follows the pin again
		ext_en <= 1'b1;
		par_pin <= ~r;
		step(4);
		rd(8'h01, 12'h002, {10'h000, ~r, 1'b0});
		// RGB vsync selected: repeated parity at two RGB edges
		rgb_sel <= 1'b1;
		repeat (2) begin
			rgb_vs <= 1'b1;
			step(4);
			rgb_vs <= 1'b0;
			step(4);
		end
		rd(8'h01, 12'h008, 12'h008);
		step(3);
		print_verdict();
	end
endmodule : his_status_regs_tb
